/* design/aup_clkgen.sv */
/*
 * Bit clock divider for host role: square wave with half period div.
 * Assumes div is stable while running; values below the minimum are raised.
 */
`timescale 1ns/1ps
module aup_clkgen import aup_pkg::*; #(
    parameter int unsigned DIV_W = 8
) (
    // Clocking
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    // Control
    input  wire logic             en,
    input  wire logic [DIV_W-1:0] div,
    // Bit clock
    output logic                  sclk,
    output logic                  rise_p,
    output logic                  fall_p
);
    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] nxt_cnt;
    logic             sclk_ff;
    logic             nxt_sclk;
    logic [DIV_W-1:0] half;
    logic             tick;

    initial begin
        if (DIV_W < 2 || (2 ** DIV_W) <= AUP_DIV_MIN) begin
            $error("aup_clkgen DIV_W too small for the minimum half period");
        end
    end

    // Half period with floor, toggle when count reaches half minus one
    always_comb begin
        half     = (div < DIV_W'(AUP_DIV_MIN)) ? DIV_W'(AUP_DIV_MIN) : div;
        tick     = en && (cnt_ff == half - DIV_W'(1));
        nxt_cnt  = (!en || tick) ? '0 : cnt_ff + DIV_W'(1);
        nxt_sclk = en ? (sclk_ff ^ tick) : 1'b0;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff  <= '0;
            sclk_ff <= 1'b0;
        end else if (ce) begin
            cnt_ff  <= nxt_cnt;
            sclk_ff <= nxt_sclk;
        end
    end

    // Edge pulses mark the cycle in which the new level appears
    logic sclk_d_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_d_ff <= 1'b0;
        end else if (ce) begin
            sclk_d_ff <= sclk_ff;
        end
    end

    assign sclk   = sclk_ff;
    assign rise_p = ce && sclk_ff && !sclk_d_ff;
    assign fall_p = ce && !sclk_ff && sclk_d_ff;
endmodule

/* design/aup_codec_port.sv */
/*
 * Codec-side end of the serial voice audio link with an Avalon-MM register
 * port. Runs as clock host or local end, PCM short sync or I2S long sync.
 * Assumes link pins are asynchronous; software owns the sample-rate divider.
 */
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module aup_codec_port import aup_pkg::*; #(
    parameter int unsigned DIV_W = 8
) (
    // Clocking
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Serial audio link
    input  wire logic        sclk_i,
    output logic             sclk_o,
    output logic             sclk_oe,
    input  wire logic        sync_i,
    output logic             sync_o,
    output logic             sync_oe,
    input  wire logic        sdi,
    output logic             sdo
);
    typedef enum logic [2:0] {
        AUP_IDLE  = 3'b001,
        AUP_ALIGN = 3'b010,
        AUP_RUN   = 3'b100
    } aup_state_e;

    initial begin
        if (DIV_W < 2 || DIV_W > 16) begin
            $error("aup_codec_port DIV_W must lie in 2..16");
        end
    end

    // Register state
    logic [AUP_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [DIV_W-1:0]      div_ff, nxt_div;
    logic [31:0]           tx_word_ff, nxt_tx_word;
    logic [31:0]           rx_word_ff, nxt_rx_word;
    logic                  rxv_ff, nxt_rxv;
    logic                  rxovr_ff, nxt_rxovr;
    logic                  txe_ff, nxt_txe;
    logic                  rd_ack_ff, nxt_rd_ack;
    logic [31:0]           rdata_ff, nxt_rdata;
    // Framing state
    aup_state_e            state_ff, nxt_state;
    logic [5:0]            cnt_ff, nxt_cnt;
    logic [31:0]           tx_frame_ff, nxt_tx_frame;
    logic [31:0]           rx_sh_ff, nxt_rx_sh;
    logic                  sync_o_ff, nxt_sync_o;
    logic                  sdo_ff, nxt_sdo;
    logic                  prev_sclk_ff, nxt_prev_sclk;
    logic                  prev_sync_ff, nxt_prev_sync;

    // Decoded control
    logic en, host, i2s, pcm18;
    assign en    = ctrl_ff[AUP_CTRL_EN];
    assign host  = ctrl_ff[AUP_CTRL_HOST];
    assign i2s   = ctrl_ff[AUP_CTRL_I2S];
    assign pcm18 = ctrl_ff[AUP_CTRL_PCM18];

    // Synchronised pins
    logic s_sclk, s_sync, s_sdi;
    aup_sync2 #(.W(3)) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .din     ({sclk_i, sync_i, sdi}),
        .dout    ({s_sclk, s_sync, s_sdi})
    );

    // Own bit clock when host
    logic g_sclk, g_rise, g_fall;
    aup_clkgen #(.DIV_W(DIV_W)) u_clkgen (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .en      (en && host),
        .div     (div_ff),
        .sclk    (g_sclk),
        .rise_p  (g_rise),
        .fall_p  (g_fall)
    );

    // Bit clock edges from own divider or from the far end
    logic rise_p, fall_p;
    assign rise_p = en && (host ? g_rise : (ce && s_sclk && !prev_sclk_ff));
    assign fall_p = en && (host ? g_fall : (ce && !s_sclk && prev_sclk_ff));

    // Bus handshake: reads take two cycles, writes one
    logic rd_done, wr_do;
    assign avs_waitrequest = (avs_read || avs_write) && (!ce || (avs_read && !rd_ack_ff));
    assign rd_done         = avs_read && ce && rd_ack_ff;
    assign wr_do           = avs_write && ce;
    assign avs_readdata    = rdata_ff;

    // Framing events
    logic [5:0] flen;
    logic [5:0] cur_bit;
    logic       frame_load;
    logic       rx_done;
    logic [31:0] sh_in;

    // Link framing, shift registers and alignment
    always_comb begin
        flen          = aup_frame_len(i2s, pcm18);
        cur_bit       = aup_bit_idx(i2s, pcm18, cnt_ff);
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_tx_frame  = tx_frame_ff;
        nxt_rx_sh     = rx_sh_ff;
        nxt_sync_o    = sync_o_ff;
        nxt_sdo       = sdo_ff;
        nxt_prev_sclk = ce ? s_sclk : prev_sclk_ff;
        nxt_prev_sync = prev_sync_ff;
        rx_done       = 1'b0;
        sh_in         = {rx_sh_ff[30:0], s_sdi};
        if (!en) begin
            nxt_state  = AUP_IDLE;
            nxt_sync_o = 1'b0;
            nxt_sdo    = 1'b0;
        end else begin
            unique case (state_ff)
                AUP_IDLE: begin
                    nxt_cnt   = flen - 6'h01;
                    nxt_state = host ? AUP_RUN : AUP_ALIGN;
                end
                AUP_ALIGN, AUP_RUN: begin
                    // Local end: lock to the far end's sync edge
                    if (!host && rise_p) begin
                        nxt_prev_sync = s_sync;
                        if (!i2s && s_sync && !prev_sync_ff) begin
                            nxt_cnt   = '0;
                            nxt_state = AUP_RUN;
                        end else if (i2s && !s_sync && prev_sync_ff) begin
                            nxt_cnt   = AUP_WS_FALL;
                            nxt_state = AUP_RUN;
                        end
                    end
                    // Sample data on rising edge
                    if (state_ff == AUP_RUN && rise_p && cur_bit[5]) begin
                        nxt_rx_sh = sh_in;
                        rx_done   = cur_bit[4:0] == (i2s ? AUP_LAST_I2S : AUP_LAST_PCM);
                    end
                    // Advance and drive on falling edge
                    if (state_ff == AUP_RUN && fall_p) begin
                        nxt_cnt = (cnt_ff >= flen - 6'h01) ? 6'h00 : cnt_ff + 6'h01;
                    end
                end
                default: begin
                    nxt_state = AUP_IDLE;
                end
            endcase
        end
        frame_load = en && state_ff == AUP_RUN && nxt_cnt == 6'h00 && cnt_ff != 6'h00;
        if (frame_load) begin
            nxt_tx_frame = tx_word_ff;
        end
        if (en && state_ff == AUP_RUN && fall_p) begin
            cur_bit    = aup_bit_idx(i2s, pcm18, nxt_cnt);
            nxt_sdo    = cur_bit[5] && nxt_tx_frame[cur_bit[4:0]];
            nxt_sync_o = host && aup_sync_level(i2s, pcm18, nxt_cnt);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff     <= AUP_IDLE;
            cnt_ff       <= '0;
            tx_frame_ff  <= '0;
            rx_sh_ff     <= '0;
            sync_o_ff    <= 1'b0;
            sdo_ff       <= 1'b0;
            prev_sclk_ff <= 1'b0;
            prev_sync_ff <= 1'b0;
        end else if (ce) begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            tx_frame_ff  <= nxt_tx_frame;
            rx_sh_ff     <= nxt_rx_sh;
            sync_o_ff    <= nxt_sync_o;
            sdo_ff       <= nxt_sdo;
            prev_sclk_ff <= nxt_prev_sclk;
            prev_sync_ff <= nxt_prev_sync;
        end
    end

    // Pin drive: clock and sync only when this end is host
    assign sclk_o  = g_sclk;
    assign sclk_oe = en && host;
    assign sync_o  = sync_o_ff;
    assign sync_oe = en && host;
    assign sdo     = sdo_ff;

    // Registers, status flags and read mux; hardware set wins over clear
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_div     = div_ff;
        nxt_tx_word = tx_word_ff;
        nxt_rx_word = rx_word_ff;
        nxt_rxv     = rxv_ff;
        nxt_rxovr   = rxovr_ff;
        nxt_txe     = txe_ff;
        nxt_rd_ack  = avs_read && !rd_ack_ff;
        nxt_rdata   = rdata_ff;
        if (avs_read && !rd_ack_ff) begin
            unique case (avs_address)
                AUP_REG_CTRL:   nxt_rdata = 32'(ctrl_ff);
                AUP_REG_STATUS: nxt_rdata = 32'({state_ff == AUP_RUN, txe_ff, rxovr_ff, rxv_ff});
                AUP_REG_TXDATA: nxt_rdata = tx_word_ff;
                AUP_REG_RXDATA: nxt_rdata = rx_word_ff;
                AUP_REG_DIV:    nxt_rdata = 32'(div_ff);
                default:        nxt_rdata = 32'h0000_0000;
            endcase
        end
        if (rd_done && avs_address == AUP_REG_RXDATA) begin
            nxt_rxv = 1'b0;
        end
        if (wr_do) begin
            unique case (avs_address)
                AUP_REG_CTRL:   nxt_ctrl    = avs_writedata[AUP_CTRL_W-1:0];
                AUP_REG_TXDATA: begin
                    nxt_tx_word = avs_writedata;
                    nxt_txe     = 1'b0;
                end
                AUP_REG_STATUS: begin
                    if (avs_writedata[AUP_ST_RXOVR]) begin
                        nxt_rxovr = 1'b0;
                    end
                end
                AUP_REG_DIV:    nxt_div     = avs_writedata[DIV_W-1:0];
                default:        nxt_ctrl    = ctrl_ff;
            endcase
        end
        if (frame_load) begin
            nxt_txe = 1'b1;
        end
        if (rx_done) begin
            nxt_rx_word = i2s ? sh_in : {sh_in[15:0], 16'h0000};
            nxt_rxovr   = nxt_rxovr || rxv_ff;
            nxt_rxv     = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff    <= AUP_CTRL_RST;
            div_ff     <= DIV_W'(AUP_DIV_RST);
            tx_word_ff <= '0;
            rx_word_ff <= '0;
            rxv_ff     <= 1'b0;
            rxovr_ff   <= 1'b0;
            txe_ff     <= 1'b0;
            rd_ack_ff  <= 1'b0;
            rdata_ff   <= '0;
        end else if (ce) begin
            ctrl_ff    <= nxt_ctrl;
            div_ff     <= nxt_div;
            tx_word_ff <= nxt_tx_word;
            rx_word_ff <= nxt_rx_word;
            rxv_ff     <= nxt_rxv;
            rxovr_ff   <= nxt_rxovr;
            txe_ff     <= nxt_txe;
            rd_ack_ff  <= nxt_rd_ack;
            rdata_ff   <= nxt_rdata;
        end
    end

    // Checks on link behaviour
    default clocking aup_cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_ROLE_LOCAL_QUIET: assert property (!host |-> !sclk_oe && !sync_oe)
        else $error("local end drives clock or sync");
    AST_FRAME_WRAP: assert property (state_ff == AUP_RUN && fall_p && en
        && cnt_ff == flen - 6'h01 |=> cnt_ff == 6'h00)
        else $error("frame counter did not wrap at frame length");
    AST_MSB_FIRST: assert property (host && !i2s && state_ff == AUP_RUN && fall_p
        && cnt_ff == aup_sync_len(pcm18) - 6'h01 |=> sdo == tx_frame_ff[AUP_TOP_IDX])
        else $error("first data bit is not the sample MSB");
    AST_WORD_END: assert property (rx_done |-> (i2s ? (cnt_ff == AUP_WS_RISE
        || cnt_ff == AUP_WS_FALL) : (cnt_ff == flen - 6'h01)))
        else $error("receive word ended off its sixteenth cycle");
    AST_PCM_LEN: assert property (host && !i2s && state_ff == AUP_RUN && fall_p
        |=> $changed(pcm18) || cnt_ff < (pcm18 ? AUP_PCM18_LEN : AUP_PCM17_LEN))
        else $error("PCM frame counter ran past frame length");
    AST_PCM_SYNC: assert property (host && !i2s && $rose(sync_o)
        |-> cnt_ff == 6'h00 ##0 (sync_o && cnt_ff == 6'h00))
        else $error("PCM sync rose off frame start");
    AST_PCM_SYNC_LEN: assert property (host && !i2s && en && $fell(sync_o)
        |-> cnt_ff == (pcm18 ? AUP_SYNC18 : AUP_SYNC17))
        else $error("PCM sync high for wrong number of bit clocks");
    AST_I2S_WS: assert property (host && i2s && en && $fell(sync_o) |-> cnt_ff == AUP_WS_FALL)
        else $error("I2S word select fell off the last slot cycle");
    AST_CLK_HALF: assert property (host && en && $changed(sclk_o) && ce
        |=> (!en || $stable(sclk_o)) [*2])
        else $error("bit clock half period below minimum");
    AST_SDO_EDGE: assert property (ce && $changed(sdo) && en |-> $past(fall_p) || !$past(en))
        else $error("data changed away from a falling edge");

    COV_PCM_FRAME: cover property (host && !i2s && fall_p && cnt_ff == flen - 6'h01);
    COV_I2S_FRAME: cover property (i2s && rx_done);
    COV_LOCAL_LOCK: cover property (state_ff == AUP_ALIGN ##1 state_ff == AUP_RUN);
    COV_RX_OVERRUN: cover property ($rose(rxovr_ff));
endmodule

/* design/aup_sync2.sv */
/*
 * Two-flop synchroniser for pins entering the system clock domain.
 * Assumes inputs are asynchronous levels; only the second stage is read.
 */
`timescale 1ns/1ps
module aup_sync2 #(
    parameter int unsigned W = 1
) (
    // Clocking
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    initial begin
        if (W < 1) begin
            $error("aup_sync2 needs W of at least 1");
        end
    end

    // Two stages, frozen while ce is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce) begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

/* pkg/aup_pkg.sv */
/*
 * Constants and helpers for the codec-side serial voice audio port.
 * Assumes a 125 MHz system clock and a byte-addressed Avalon-MM slave.
 */
package aup_pkg;

    // Register byte offsets
    localparam logic [4:0]  AUP_REG_CTRL   = 5'h00;
    localparam logic [4:0]  AUP_REG_STATUS = 5'h04;
    localparam logic [4:0]  AUP_REG_TXDATA = 5'h08;
    localparam logic [4:0]  AUP_REG_RXDATA = 5'h0C;
    localparam logic [4:0]  AUP_REG_DIV    = 5'h10;

    // Control fields
    localparam int unsigned AUP_CTRL_EN    = 0;
    localparam int unsigned AUP_CTRL_HOST  = 1;
    localparam int unsigned AUP_CTRL_I2S   = 2;
    localparam int unsigned AUP_CTRL_PCM18 = 3;
    localparam int unsigned AUP_CTRL_W     = 4;
    localparam logic [3:0]  AUP_CTRL_RST   = 4'h0;

    // Status fields
    localparam int unsigned AUP_ST_RXV     = 0;
    localparam int unsigned AUP_ST_RXOVR   = 1;
    localparam int unsigned AUP_ST_TXE     = 2;
    localparam int unsigned AUP_ST_ALIGNED = 3;

    // Bit clock half period in system clocks
    localparam int unsigned AUP_DIV_MIN    = 3;
    localparam int unsigned AUP_DIV_RST    = 5;

    // Frame geometry
    localparam logic [5:0]  AUP_PCM17_LEN  = 6'h11;
    localparam logic [5:0]  AUP_PCM18_LEN  = 6'h12;
    localparam logic [5:0]  AUP_I2S_LEN    = 6'h20;
    localparam logic [5:0]  AUP_SYNC17     = 6'h01;
    localparam logic [5:0]  AUP_SYNC18     = 6'h02;
    localparam logic [5:0]  AUP_WORD_BITS  = 6'h10;
    localparam logic [5:0]  AUP_WS_RISE    = 6'h0F;
    localparam logic [5:0]  AUP_WS_FALL    = 6'h1F;
    localparam logic [4:0]  AUP_TOP_IDX    = 5'h1F;
    localparam logic [4:0]  AUP_LAST_I2S   = 5'h00;
    localparam logic [4:0]  AUP_LAST_PCM   = 5'h10;

    function automatic logic [5:0] aup_frame_len(input logic i2s, input logic pcm18);
        return i2s ? AUP_I2S_LEN : (pcm18 ? AUP_PCM18_LEN : AUP_PCM17_LEN);
    endfunction

    function automatic logic [5:0] aup_sync_len(input logic pcm18);
        return pcm18 ? AUP_SYNC18 : AUP_SYNC17;
    endfunction

    // Valid flag and frame-word bit index for a given bit cycle
    function automatic logic [5:0] aup_bit_idx(input logic i2s, input logic pcm18,
                                               input logic [5:0] cnt);
        logic [5:0] d;
        d = cnt - aup_sync_len(pcm18);
        if (i2s) begin
            return {1'b1, AUP_TOP_IDX - cnt[4:0]};
        end
        return {(cnt >= aup_sync_len(pcm18)) && (d < AUP_WORD_BITS), AUP_TOP_IDX - d[4:0]};
    endfunction

    // Sync level driven during a bit cycle
    function automatic logic aup_sync_level(input logic i2s, input logic pcm18,
                                            input logic [5:0] cnt);
        return i2s ? (cnt >= AUP_WS_RISE && cnt < AUP_WS_FALL) : (cnt < aup_sync_len(pcm18));
    endfunction

endpackage

/* tb/aup_module_model.sv */
/*
 * Behavioural model of the module end of the serial voice link.
 * Assumes the bench resolves the shared clock and sync wires from all enables.
 */
`timescale 1ns/1ps
module aup_module_model (
    // Role and framing
    input  wire logic        host,
    input  wire logic        i2s,
    input  wire logic        pcm18,
    input  wire logic [31:0] tx_word,
    // Link wires
    input  wire logic        sclk_w,
    input  wire logic        sync_w,
    input  wire logic        sdo,
    output logic             sclk_m,
    output logic             sync_m,
    output logic             sdi,
    // Observations
    output logic      [31:0] rx_word,
    output int               frames,
    output int               flen,
    output int               shigh,
    output time              fper,
    // Codec reference clock
    output logic             ref_clk
);
    int   c = 63;
    int   n = 0;
    int   hi = 0;
    int   s;
    int   len;
    logic sync_q = 1'b0;
    time  t0 = 0;

    // Frame geometry of the selected mode
    assign s   = pcm18 ? 2 : 1;
    assign len = i2s ? 32 : (pcm18 ? 18 : 17);

    // Word bit carried in cycle k, or -1 outside the word
    function automatic int idx(input int k);
        if (i2s) return 31 - k;
        return (k >= s && k < s + 16) ? 31 - (k - s) : -1;
    endfunction

    // Own bit clock of 80 ns, still while the model is local
    initial begin
        sclk_m = 1'b0;
        sync_m = 1'b0;
        sdi    = 1'b0;
        #3;
        forever #40 sclk_m = host ? ~sclk_m : 1'b0;
    end

    // Continuous reference clock for the codec, free of the link
    initial begin
        ref_clk = 1'b0;
        forever #30 ref_clk = ~ref_clk;
    end

    // Sync and data change after the falling edge
    always @(negedge sclk_w) begin
        c = (c >= len - 1) ? 0 : c + 1;
        sync_m = i2s ? (c >= 15 && c < 31) : (c < s);
        sdi = (idx(c) >= 0) ? tx_word[idx(c)] : ~sdi;
    end

    // Rising edge samples; a local end aligns on sync
    always @(posedge sclk_w) begin
        if (!host && !i2s && sync_w && !sync_q) c = 0;
        if (!host && i2s && !sync_w && sync_q) c = 31;
        n = n + 1;
        hi = hi + (sync_w ? 1 : 0);
        sync_q = sync_w;
        if (idx(c) >= 0) rx_word[idx(c)] = sdo;
        if (c == len - 1) begin
            frames = frames + 1;
            flen = n;
            shigh = hi;
            fper = $time - t0;
            n = 0;
            hi = 0;
            t0 = $time;
        end
    end
endmodule

/* tb/tb_aup_codec_port.sv */
/*
 * Self-checking bench for the codec-side serial audio port.
 * Assumes the module model stands on the far side of the link.
 */
`timescale 1ns/1ps
module tb_aup_codec_port import aup_pkg::*; ;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        ce = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata, rx_word, q;
    logic        avs_waitrequest, sclk_o, sclk_oe, sync_o, sync_oe, sdo;
    logic        m_host = 1'b0, m_i2s = 1'b0, m_pcm18 = 1'b0, tgl = 1'b0;
    logic [31:0] m_tx = 32'h00000000;
    logic        sclk_m, sync_m, sdi, sclk_w, sync_w, ref_clk;
    int          refs = 0;
    int          frames, flen, shigh;
    time         fper;
    int          errors = 0;
    int          checked = 0;

    // Clock and a toggling level for undriven wires
    always #4 clk = ~clk;
    always @(posedge clk) tgl <= ~tgl;
    always @(posedge ref_clk) refs++;
    assign sclk_w = sclk_oe ? sclk_o : (m_host ? sclk_m : tgl);
    assign sync_w = sync_oe ? sync_o : (m_host ? sync_m : ~tgl);

    aup_codec_port #(.DIV_W(8)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sync_i(sync_w),
        .sync_o(sync_o), .sync_oe(sync_oe), .sdi(sdi), .sdo(sdo));

    aup_module_model i_mdl (
        .host(m_host), .i2s(m_i2s), .pcm18(m_pcm18), .tx_word(m_tx),
        .sclk_w(sclk_w), .sync_w(sync_w), .sdo(sdo), .sclk_m(sclk_m),
        .sync_m(sync_m), .sdi(sdi), .rx_word(rx_word), .frames(frames),
        .flen(flen), .shigh(shigh), .fper(fper), .ref_clk(ref_clk));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One Avalon transfer, held until waitrequest is low at an edge
    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
        logic ws;
        int   n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin
            @(posedge clk);
            ws = avs_waitrequest;
            rd = avs_readdata;
            n++;
        end while (ws !== 1'b0 && n < 100);
        chk("waitrequest", 32'h00000000, {31'h0, ws});
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wait_frames(input int k);
        int f0;
        int n;
        f0 = frames;
        n = 0;
        while (frames < f0 + k && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk("frame_wait", 32'h00000001, {31'h0, n < 20000});
    endtask

    task automatic test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Reset values, unmapped and read-only places, idle pins
    task automatic t_regs();
        logic [4:0]  a [5] = '{AUP_REG_CTRL, AUP_REG_STATUS, AUP_REG_DIV, AUP_REG_RXDATA, 5'h14};
        logic [31:0] e [5] = '{32'h0, 32'h0, 32'h5, 32'h0, 32'h0};
        chk("idle_pins", 32'h0, {27'h0, sclk_o, sclk_oe, sync_o, sync_oe, sdo});
        av(1'b1, 5'h14, 32'hFFFFFFFF, q);
        av(1'b1, AUP_REG_RXDATA, 32'hFFFFFFFF, q);
        for (int i = 0; i < 5; i++) begin
            av(1'b0, a[i], 32'h0, q);
            chk("reset_reg", e[i], q);
        end
        av(1'b1, AUP_REG_TXDATA, 32'h1234ABCD, q);
        av(1'b0, AUP_REG_TXDATA, 32'h0, q);
        chk("txdata", 32'h1234ABCD, q);
        $display("test t_regs done");
    endtask

    // Design as clock host, model local
    task automatic t_host(input logic [31:0] ctl, input logic [7:0] div,
                          input int len, input int sh);
        logic [31:0] mask;
        mask = ctl[AUP_CTRL_I2S] ? 32'hFFFFFFFF : 32'hFFFF0000;
        m_host <= 1'b0;
        m_i2s <= ctl[AUP_CTRL_I2S];
        m_pcm18 <= ctl[AUP_CTRL_PCM18];
        m_tx <= 32'h5A3C96E1 ^ ctl;
        av(1'b1, AUP_REG_DIV, {24'h0, div}, q);
        av(1'b1, AUP_REG_TXDATA, 32'hC3A50F69 ^ ctl, q);
        av(1'b1, AUP_REG_CTRL, ctl, q);
        wait_frames(4);
        chk("sclk_oe", 32'h1, {31'h0, sclk_oe & sync_oe});
        chk("frame_len", len, flen);
        chk("sync_high", sh, shigh);
        chk("frame_ns", 32'(16 * (div < 3 ? 3 : div) * len), 32'(fper));
        chk("link_rx", (32'hC3A50F69 ^ ctl) & mask, rx_word & mask);
        av(1'b0, AUP_REG_STATUS, 32'h0, q);
        chk("status", 32'hF, q & 32'hF);
        av(1'b0, AUP_REG_RXDATA, 32'h0, q);
        chk("rxdata", m_tx & mask, q);
        av(1'b1, AUP_REG_CTRL, 32'h0, q);
        $display("test t_host ctrl %h done", ctl);
    endtask

    // Design local, model makes clock and sync
    task automatic t_local(input logic [31:0] ctl);
        logic [31:0] mask;
        int          r;
        mask = ctl[AUP_CTRL_I2S] ? 32'hFFFFFFFF : 32'hFFFF0000;
        m_host <= 1'b1;
        m_i2s <= ctl[AUP_CTRL_I2S];
        m_pcm18 <= 1'b0;
        m_tx <= 32'h8001F00F ^ ctl;
        av(1'b1, AUP_REG_TXDATA, 32'h7FFE0FF0 ^ ctl, q);
        av(1'b1, AUP_REG_CTRL, ctl, q);
        r = refs;
        wait_frames(4);
        chk("local_oe", 32'h0, {30'h0, sclk_oe, sync_oe});
        chk("ref_clk", 32'h1, {31'h0, refs > r});
        chk("link_rx", (32'h7FFE0FF0 ^ ctl) & mask, rx_word & mask);
        av(1'b0, AUP_REG_RXDATA, 32'h0, q);
        chk("rxdata", m_tx & mask, q);
        av(1'b1, AUP_REG_CTRL, 32'h0, q);
        m_host <= 1'b0;
        $display("test t_local ctrl %h done", ctl);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_host(32'h3, 8'h05, 17, 1);
        t_host(32'hB, 8'h02, 18, 2);
        t_host(32'h7, 8'h04, 32, 16);
        t_local(32'h1);
        t_local(32'h5);
        test_done();
    end

    // Watchdog
    initial begin
        #200000;
        errors++;
        test_done();
    end
endmodule
